// [hdl/crc_pkg.sv]
// Package with constants and types for the checksum engine
package crc_pkg;

  // Polynomial selection codes
  typedef enum logic [1:0] {
    POLY_CCITT = 2'h0,
    POLY_CRC16 = 2'h1,
    POLY_CRC32 = 2'h2
  } poly_sel_e;

  // Write width codes
  typedef enum logic [1:0] {
    WIDTH_BYTE = 2'h0,
    WIDTH_HALF = 2'h1,
    WIDTH_WORD = 2'h2
  } write_width_e;

  // Generator terms, highest power implied
  localparam logic [31:0] POLY_CCITT_TERMS = 32'h0000_1021;
  localparam logic [31:0] POLY_CRC16_TERMS = 32'h0000_8005;
  localparam logic [31:0] POLY_CRC32_TERMS = 32'h04c1_1db7;

  // Accumulator reset value
  localparam logic [31:0] SEED_RESET = 32'h0000_0000;

  // Byte counts per write width
  localparam logic [2:0] BYTES_BYTE = 3'h1;
  localparam logic [2:0] BYTES_HALF = 3'h2;
  localparam logic [2:0] BYTES_WORD = 3'h4;
  localparam int         BYTE_BITS  = 8;

endpackage : crc_pkg

// [hdl/crc_stream_if.sv]
// Interface carrying data words between buffer and engine
`timescale 1ns/1ps
interface crc_stream_if;
  logic                 valid;
  logic                 ready;
  logic [31:0]          data;
  crc_pkg::write_width_e width;

  modport source (output valid, output data, output width, input ready);
  modport sink   (input valid, input data, input width, output ready);
endinterface : crc_stream_if

// [hdl/crc_skid_buffer.sv]
// Two-entry buffer between the write port and the checksum core
`timescale 1ns/1ps
module crc_skid_buffer (
  // Clock and reset
  input  wire logic                  i_clock,
  input  wire logic                  i_reset_n,
  // Filling side
  input  wire logic                  i_valid,
  output logic                       o_ready,
  input  wire logic [31:0]           i_data,
  input  wire crc_pkg::write_width_e i_width,
  // Draining side
  crc_stream_if.source               out
);
  import crc_pkg::*;

  // ==========================================================
  // Storage
  logic [31:0]    data_ff  [2];
  write_width_e   width_ff [2];
  logic           wr_ptr_ff;
  logic           rd_ptr_ff;
  logic [1:0]     count_ff;
  logic           push;
  logic           pop;

  // Handshake terms
  assign o_ready   = (count_ff != 2'h2);
  assign push      = i_valid && o_ready;
  assign pop       = out.valid && out.ready;
  assign out.valid = (count_ff != 2'h0);
  assign out.data  = data_ff[rd_ptr_ff];
  assign out.width = width_ff[rd_ptr_ff];

  // Entry writes
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      data_ff[0]  <= 32'h0;
      data_ff[1]  <= 32'h0;
      width_ff[0] <= WIDTH_BYTE;
      width_ff[1] <= WIDTH_BYTE;
    end else if (push) begin
      data_ff[wr_ptr_ff]  <= i_data;
      width_ff[wr_ptr_ff] <= i_width;
    end
  end

  // Pointers and fill level
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wr_ptr_ff <= 1'b0;
      rd_ptr_ff <= 1'b0;
      count_ff  <= 2'h0;
    end else begin
      if (push) wr_ptr_ff <= ~wr_ptr_ff;
      if (pop)  rd_ptr_ff <= ~rd_ptr_ff;
      count_ff <= count_ff + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule : crc_skid_buffer

// [hdl/crc_byte_step.sv]
// Combinational one-byte checksum step for any polynomial of degree 16 or 32
`timescale 1ns/1ps
module crc_byte_step (
  // Operands
  input  wire logic [31:0] i_crc,
  input  wire logic [7:0]  i_byte,
  input  wire logic [31:0] i_poly,
  input  wire logic        i_wide,
  // Result
  output logic [31:0]      o_crc
);
  // Eight MSB-first shift steps; narrow mode uses bit 15 as top
  always_comb begin
    logic [31:0] c;
    logic        fb;
    c = i_crc;
    fb = 1'b0;
    for (int b = 0; b < 8; b++) begin
      fb = (i_wide ? c[31] : c[15]) ^ i_byte[7 - b];
      c  = {c[30:0], 1'b0} ^ (fb ? i_poly : 32'h0);
    end
    o_crc = i_wide ? c : {16'h0, c[15:0]};
  end
endmodule : crc_byte_step

// [hdl/crc_checksum_engine.sv]
// Checksum engine top: configuration, byte sequencer and result path
// Notes on behaviour
// - The CCITT choice uses generator terms 16, 12, 5 and 0.
// - The 16-bit standard choice uses generator terms 16, 15, 2 and 0.
// - The 32-bit choice uses terms 32,26,23,22,16,12,11,10,8,7,5,4,2,1,0.
// - Input data and the result each have their own bit-reverse and complement options.
// - A programmed seed initialises the accumulator before data is processed.
// - Data may come from single processor writes or gap-free DMA writes.
// - Each write is 8, 16 or 32 bits and is processed by that width.
// - A byte write is absorbed in one clock cycle.
// - A halfword write takes two byte steps over two cycles.
// - A word write takes four byte steps over four cycles.
`timescale 1ns/1ps
module crc_checksum_engine (
  // Clock and reset
  input  wire logic                  i_clock,
  input  wire logic                  i_reset_n,
  // Configuration
  input  wire crc_pkg::poly_sel_e    i_poly_sel,
  input  wire logic                  i_data_reverse,
  input  wire logic                  i_data_complement,
  input  wire logic                  i_sum_reverse,
  input  wire logic                  i_sum_complement,
  // Seed load
  input  wire logic                  i_seed_write,
  input  wire logic [31:0]           i_seed,
  // Data write
  input  wire logic                  i_data_valid,
  output logic                       o_data_ready,
  input  wire logic [31:0]           i_data,
  input  wire crc_pkg::write_width_e i_data_width,
  // Result
  output logic [31:0]                o_sum,
  output logic                       o_busy
);
  import crc_pkg::*;

  // ==========================================================
  // Local types

  // Sequencer states, Gray coded along idle, run, idle
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01
  } step_state_e;

  // ==========================================================
  // Elaboration checks

  // The byte counts must cover the 32-bit data port exactly
  if (int'(BYTES_WORD) * BYTE_BITS != 32) begin : g_bad_word
    $error("word byte count does not fill the data port");
  end

  // A halfword must be two byte steps of the narrow sum
  if (int'(BYTES_HALF) * BYTE_BITS != 16) begin : g_bad_half
    $error("halfword byte count does not fill 16 bits");
  end

  // The sequencer counts down in single byte steps
  if (int'(BYTES_BYTE) != 1) begin : g_bad_byte
    $error("byte write must be a single step");
  end

  // ==========================================================
  // Helper functions

  // Mirror all 32 bits
  function automatic logic [31:0] bit_rev32(input logic [31:0] v);
    logic [31:0] r;
    r = 32'h0;
    for (int i = 0; i < 32; i++) begin
      r[i] = v[31 - i];
    end
    return r;
  endfunction : bit_rev32

  // Mirror the low 16 bits, upper half cleared
  function automatic logic [31:0] bit_rev16(input logic [31:0] v);
    logic [31:0] r;
    r = 32'h0;
    for (int i = 0; i < 16; i++) begin
      r[i] = v[15 - i];
    end
    return r;
  endfunction : bit_rev16

  // Mirror one byte
  function automatic logic [7:0] bit_rev8(input logic [7:0] v);
    logic [7:0] r;
    r = 8'h0;
    for (int i = 0; i < 8; i++) begin
      r[i] = v[7 - i];
    end
    return r;
  endfunction : bit_rev8

  // Keep all 32 bits for the wide sum, else only the low half
  function automatic logic [31:0] fit_sum(input logic [31:0] v, input logic w);
    return w ? v : {16'h0, v[15:0]};
  endfunction : fit_sum

  // Byte steps taken by one write
  function automatic logic [2:0] width_bytes(input write_width_e w);
    case (w)
      WIDTH_BYTE: return BYTES_BYTE;
      WIDTH_HALF: return BYTES_HALF;
      default:    return BYTES_WORD;
    endcase
  endfunction : width_bytes

  // Input options on one byte: reverse first, then complement
  function automatic logic [7:0] data_opts(input logic [7:0] b, input logic rev, input logic inv);
    logic [7:0] r;
    r = rev ? bit_rev8(b) : b;
    if (inv) begin
      r = ~r;
    end
    return r;
  endfunction : data_opts

  // Result options: reverse over the sum width, then complement
  function automatic logic [31:0] sum_opts(input logic [31:0] a, input logic w, input logic rev,
                                           input logic inv);
    logic [31:0] r;
    r = fit_sum(a, w);
    if (rev) begin
      r = w ? bit_rev32(r) : bit_rev16(r);
    end
    if (inv) begin
      r = ~r;
    end
    return fit_sum(r, w);
  endfunction : sum_opts

  // ==========================================================
  // Input buffer

  // Two entries, so a stalled core loses no accepted write
  crc_stream_if stream ();

  // Writes enter here and leave towards the byte sequencer
  crc_skid_buffer u_buffer (
    .i_clock   (i_clock),
    .i_reset_n (i_reset_n),
    .i_valid   (i_data_valid),
    .o_ready   (o_data_ready),
    .i_data    (i_data),
    .i_width   (i_data_width),
    .out       (stream.source)
  );

  // ==========================================================
  // Sequencer signals

  step_state_e  state_ff;  // Idle or inside a multi-byte write
  logic [2:0]   left_ff;   // Byte steps still to come
  logic [31:0]  word_ff;   // Unprocessed upper bytes, low byte next
  logic [31:0]  acc_ff;    // Checksum accumulator
  logic         load;      // Buffer head taken this cycle
  logic         last_step; // Final byte of a multi-byte write
  logic         stepping;  // A byte enters the accumulator
  logic [7:0]   cur_byte;  // Raw byte of this step
  logic [7:0]   in_byte;   // Byte after input options
  logic [31:0]  poly;      // Generator terms in use
  logic         wide;      // 32-bit sum selected
  logic [31:0]  acc_next;  // Accumulator after one byte step
  logic [31:0]  sum_view;  // Accumulator after result options

  // ==========================================================
  // Handshake and step control

  // Take a new write only when idle; a seed write stalls the head.
  // Taking it on the last byte of a word would skip its first byte,
  // so a word holds the buffer head for its full four cycles.
  assign stream.ready = (state_ff == ST_IDLE) && !i_seed_write;
  assign load         = stream.valid && stream.ready;
  assign last_step    = (state_ff == ST_RUN) && (left_ff == BYTES_BYTE);
  assign stepping     = ((state_ff == ST_RUN) || load) && !i_seed_write;
  assign o_busy       = (state_ff == ST_RUN);

  // ==========================================================
  // Polynomial choice

  // Codes 2 and 3 both select the 32-bit sum
  always_comb begin
    case (i_poly_sel)
      POLY_CCITT: begin
        poly = POLY_CCITT_TERMS;
        wide = 1'b0;
      end
      POLY_CRC16: begin
        poly = POLY_CRC16_TERMS;
        wide = 1'b0;
      end
      default: begin
        poly = POLY_CRC32_TERMS;
        wide = 1'b1;
      end
    endcase
  end

  // ==========================================================
  // Byte path

  // Freshly taken low byte when idle, else the next stored byte
  always_comb begin
    if (state_ff == ST_RUN) begin
      cur_byte = word_ff[7:0];
    end else begin
      cur_byte = stream.data[7:0];
    end
  end

  // Input reverse and complement on every byte
  assign in_byte = data_opts(cur_byte, i_data_reverse, i_data_complement);

  // One byte through the generator per cycle
  crc_byte_step u_step (
    .i_crc  (acc_ff),
    .i_byte (in_byte),
    .i_poly (poly),
    .i_wide (wide),
    .o_crc  (acc_next)
  );

  // ==========================================================
  // Sequencer registers

  // State: byte writes finish at once, wider ones run on
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_ff <= ST_IDLE;
    end else if (i_seed_write) begin
      state_ff <= ST_IDLE;
    end else if (load && (width_bytes(stream.width) != BYTES_BYTE)) begin
      state_ff <= ST_RUN;
    end else if (last_step) begin
      state_ff <= ST_IDLE;
    end
  end

  // Remaining byte steps of the write in progress
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      left_ff <= 3'h0;
    end else if (i_seed_write) begin
      left_ff <= 3'h0;
    end else if (load) begin
      left_ff <= width_bytes(stream.width) - BYTES_BYTE;
    end else if (last_step) begin
      left_ff <= 3'h0;
    end else if (state_ff == ST_RUN) begin
      left_ff <= left_ff - BYTES_BYTE;
    end
  end

  // Upper bytes wait here, next byte in the low lane
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      word_ff <= 32'h0;
    end else if (load) begin
      word_ff <= {8'h0, stream.data[31:BYTE_BITS]};
    end else if (state_ff == ST_RUN) begin
      word_ff <= {8'h0, word_ff[31:BYTE_BITS]};
    end
  end

  // ==========================================================
  // Accumulator

  // Seed write wins over a data step in the same cycle
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      acc_ff <= SEED_RESET;
    end else if (i_seed_write) begin
      acc_ff <= fit_sum(i_seed, wide);
    end else if (stepping) begin
      acc_ff <= acc_next;
    end
  end

  // ==========================================================
  // Result path

  // Options act on the way out only; the accumulator is never rewritten,
  // and a narrow sum always shows a cleared upper half
  assign sum_view = sum_opts(acc_ff, wide, i_sum_reverse, i_sum_complement);

  // Registered result, one cycle behind the accumulator
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_sum <= 32'h0;
    end else begin
      o_sum <= sum_view;
    end
  end
endmodule : crc_checksum_engine

// [verification/crc_feeder.sv]
// Writer model that feeds data words into the engine
`timescale 1ns/1ps
module crc_feeder (
  // Clock and handshake
  input  wire logic           i_clock,
  input  wire logic           i_ready,
  // Write request
  output logic                o_valid,
  output logic [31:0]         o_data,
  output crc_pkg::write_width_e o_width
);
  import crc_pkg::*;
  // Idle request lines at time zero
  initial begin
    o_valid = 1'b0;
    o_data  = 32'h0;
    o_width = WIDTH_BYTE;
  end
  // One write held until taken, then an optional gap
  task send(input logic [31:0] d, input write_width_e w, input int gap);
    @(negedge i_clock);
    o_valid = 1'b1;
    o_data  = d;
    o_width = w;
    while (!i_ready) @(negedge i_clock);
    @(posedge i_clock);
    if (gap > 0) begin
      @(negedge i_clock);
      o_valid = 1'b0;
      o_data  = ~d; // Released lines do not keep old data
      repeat (gap - 1) @(negedge i_clock);
    end
  endtask : send
endmodule : crc_feeder

// [verification/crc_checksum_engine_sva.sv]
// Port-level checker for the checksum engine
`timescale 1ns/1ps
module crc_checksum_engine_sva (
  input wire logic i_clock, i_reset_n, i_data_reverse, i_data_complement,
  input wire logic i_sum_reverse, i_sum_complement, i_seed_write, i_data_valid,
  input wire logic o_data_ready, o_busy,
  input wire crc_pkg::poly_sel_e i_poly_sel,
  input wire crc_pkg::write_width_e i_data_width,
  input wire logic [31:0] i_seed, i_data, o_sum
);
  import crc_pkg::*;
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  // Quiet cycle, option word, plain seed readback cases
  wire       quiet = !i_data_valid && !i_seed_write && !o_busy;
  wire [5:0] opts  = {i_poly_sel, i_data_reverse, i_data_complement, i_sum_reverse, i_sum_complement};
  wire       w32   = i_poly_sel[1] && !i_sum_reverse && !i_sum_complement;
  wire       w16   = i_poly_sel == POLY_CCITT && !i_sum_reverse && !i_sum_complement;
  logic [3:0] idle_ff;
  // Cycles since the last write request
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) idle_ff <= 4'h0;
    else if (i_data_valid) idle_ff <= 4'h0;
    else if (idle_ff != 4'hf) idle_ff <= idle_ff + 4'h1;
  end
  property p_seed32; w32 && i_seed_write ##1 w32 && !i_seed_write |=> o_sum == $past(i_seed, 2); endproperty
  property p_seed16;
    w16 && i_seed_write ##1 w16 && !i_seed_write |=> o_sum == {16'h0000, $past(i_seed[15:0], 2)};
  endproperty
  property p_upper; (i_poly_sel inside {POLY_CCITT, POLY_CRC16})[*2] |=> o_sum[31:16] == 16'h0000; endproperty
  property p_hold; (quiet && $stable(opts))[*8] |=> $stable(o_sum); endproperty
  property p_flip;
    (quiet && $stable(opts) && i_poly_sel[1])[*8] ##1 (quiet && $changed(i_sum_complement) && $stable(opts[5:1]))
      |=> o_sum == ~$past(o_sum);
  endproperty
  property p_fell; $fell(o_data_ready) |-> $past(i_data_valid); endproperty
  property p_back; !o_data_ready && !i_seed_write |-> ##[1:6] o_data_ready; endproperty
  property p_drain; idle_ff == 4'hf |-> !o_busy && o_data_ready; endproperty
  a_seed32: assert property (p_seed32) else $error("seed32 not on sum");
  a_seed16: assert property (p_seed16) else $error("seed16 not on sum");
  a_upper: assert property (p_upper) else $error("upper half set");
  a_hold: assert property (p_hold) else $error("sum moved when quiet");
  a_flip: assert property (p_flip) else $error("complement not applied");
  a_fell: assert property (p_fell) else $error("full without write");
  a_back: assert property (p_back) else $error("buffer stuck full");
  a_drain: assert property (p_drain) else $error("not drained");
  c_word: cover property ($rose(o_busy));
  c_full: cover property ($fell(o_data_ready));
  c_abort: cover property (i_seed_write && o_busy);
endmodule : crc_checksum_engine_sva
bind crc_checksum_engine crc_checksum_engine_sva chk (.i_clock(i_clock), .i_reset_n(i_reset_n),
  .i_data_reverse(i_data_reverse), .i_data_complement(i_data_complement), .i_sum_reverse(i_sum_reverse),
  .i_sum_complement(i_sum_complement), .i_seed_write(i_seed_write), .i_data_valid(i_data_valid),
  .o_data_ready(o_data_ready), .o_busy(o_busy), .i_poly_sel(i_poly_sel), .i_data_width(i_data_width),
  .i_seed(i_seed), .i_data(i_data), .o_sum(o_sum));

// [verification/crc_checksum_engine_test.sv]
// Self-checking bench for the checksum engine
`timescale 1ns/1ps
module crc_checksum_engine_test;
  import crc_pkg::*;
  logic         clk, rst_n, sw, vld, rdy, dr, dc, sr, sc, busy;
  logic [1:0]   poly;
  logic [31:0]  seed, dat, sum, acc;
  write_width_e wid;
  int           mismatches, total_checks, busy_n, full_n;
  crc_feeder fd (.i_clock(clk), .i_ready(rdy), .o_valid(vld), .o_data(dat), .o_width(wid));
  crc_checksum_engine uut (.i_clock(clk), .i_reset_n(rst_n), .i_poly_sel(poly_sel_e'(poly)),
    .i_data_reverse(dr), .i_data_complement(dc), .i_sum_reverse(sr), .i_sum_complement(sc),
    .i_seed_write(sw), .i_seed(seed), .i_data_valid(vld), .o_data_ready(rdy), .i_data(dat),
    .i_data_width(wid), .o_sum(sum), .o_busy(busy));
  // Clock and busy or full cycle counters
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(negedge clk) begin
    if (busy === 1'b1) busy_n++;
    if (rdy === 1'b0) full_n++;
  end
  // Reference byte step, msb first
  function automatic logic [31:0] step(logic [31:0] c, logic [7:0] b);
    int w;
    logic [7:0] x;
    w = poly[1] ? 32 : 16;
    for (int i = 0; i < 8; i++) x[i] = dr ? b[7 - i] : b[i];
    if (dc) x = ~x;
    c = c ^ (32'(x) << (w - 8));
    for (int i = 0; i < 8; i++)
      c = c[w - 1] ? (c << 1) ^ (poly[1] ? POLY_CRC32_TERMS : poly[0] ? POLY_CRC16_TERMS : POLY_CCITT_TERMS) : c << 1;
    return poly[1] ? c : {16'h0, c[15:0]};
  endfunction : step
  function automatic logic [31:0] res();
    int w;
    logic [31:0] r;
    w = poly[1] ? 32 : 16;
    r = 32'h0;
    for (int i = 0; i < w; i++) r[i] = sr ? acc[w - 1 - i] : acc[i];
    if (sc) r = ~r;
    return poly[1] ? r : {16'h0, r[15:0]};
  endfunction : res
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task setup(input logic [1:0] p, input logic [3:0] o, input logic [31:0] s);
    @(negedge clk);
    poly = p;
    {dr, dc, sr, sc} = o;
    seed = s;
    sw = 1'b1;
    acc = p[1] ? s : {16'h0, s[15:0]};
    @(negedge clk);
    sw = 1'b0;
  endtask : setup
  task put(input logic [31:0] d, input write_width_e w, input int gap);
    for (int i = 0; i < (w == WIDTH_BYTE ? 1 : w == WIDTH_HALF ? 2 : 4); i++) acc = step(acc, d[8*i +: 8]);
    fd.send(d, w, gap);
  endtask : put
  // Drain, settle, compare the result
  task sum_is();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 40) begin
      @(negedge clk);
      n++;
    end
    repeat (12) @(negedge clk);
    cmp(sum, res());
  endtask : sum_is
  // ==================== Scenarios
  task t_polys();
    for (int p = 0; p < 4; p++) begin
      setup(2'(p), 4'h0, 32'hffff_ffff);
      put(32'h3433_3231, WIDTH_WORD, 1);
      sum_is();
    end
    for (int k = 0; k < 16; k++) begin
      setup(2'(k % 3), 4'(k), 32'h1234_5678);
      put(32'h0000_a5c3, WIDTH_HALF, 1);
      sum_is();
    end
    $display("polys and options done");
  endtask : t_polys
  task t_widths();
    setup(2'h1, 4'h0, 32'h0);
    busy_n = 0;
    put(32'h0000_00a7, WIDTH_BYTE, 1);
    sum_is();
    cmp(32'(busy_n), 32'h0);
    busy_n = 0;
    put(32'h0000_1b2c, WIDTH_HALF, 1);
    sum_is();
    cmp(32'(busy_n), 32'h1);
    busy_n = 0;
    put(32'h89ab_cdef, WIDTH_WORD, 1);
    sum_is();
    cmp(32'(busy_n), 32'h3);
    $display("widths done");
  endtask : t_widths
  task t_stream();
    setup(2'h2, 4'h0, 32'hffff_ffff);
    full_n = 0;
    for (int i = 0; i < 4; i++) put(32'h1111_1111 * (i + 1), WIDTH_WORD, int'(i == 3));
    sum_is();
    cmp(32'(full_n > 0), 32'h1);
    setup(2'h0, 4'h0, 32'hffff_ffff);
    full_n = 0;
    for (int i = 0; i < 8; i++) put(32'(8'h30 + i), WIDTH_BYTE, int'(i == 7));
    sum_is();
    cmp(32'(full_n), 32'h0);
    $display("stream done");
  endtask : t_stream
  task t_abort();
    int n;
    setup(2'h2, 4'h0, 32'h0);
    fd.send(32'hdead_beef, WIDTH_WORD, 1);
    for (n = 0; n < 10 && busy !== 1'b1; n++) @(negedge clk);
    sw = 1'b1;
    seed = 32'h0bad_f00d;
    acc = seed;
    @(negedge clk);
    sw = 1'b0;
    put(32'h0000_0055, WIDTH_BYTE, 1);
    sum_is();
    {sr, sc} = 2'h1;
    sum_is();
    {sr, sc} = 2'h3;
    sum_is();
    {sr, sc} = 2'h0;
    sum_is();
    $display("seed and result done");
  endtask : t_abort
  task finish_test();
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : finish_test
  // Reset, then scenarios
  initial begin
    {rst_n, sw, dr, dc, sr, sc} = 6'h0;
    poly = 2'h0;
    seed = 32'h0;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    t_polys();
    t_widths();
    t_stream();
    t_abort();
    finish_test();
  end
  // Watchdog, several times the expected run
  initial begin
    repeat (8000) @(posedge clk);
    mismatches++;
    finish_test();
  end
endmodule : crc_checksum_engine_test
